// ### shared/cicr_pkg.sv
package cicr_pkg;

  // Register byte offsets within the block's window.
  localparam logic [7:0] CICR_OFS_MAIN = 8'h00;
  localparam logic [7:0] CICR_OFS_EDGE = 8'h04;
  localparam logic [7:0] CICR_OFS_MODE = 8'h08;
  localparam logic [7:0] CICR_OFS_STAT = 8'h0C;
  localparam int CICR_OFS_W = 8;

  // Main control register fields.
  localparam int CICR_GLOBAL_OR_HIGH_ENABLE = 7;
  localparam int CICR_PERIPHERAL_OR_LOW_ENABLE = 6;
  localparam int CICR_TIMER0_OVERFLOW_ENABLE = 5;
  localparam int CICR_EXT_PIN0_ENABLE = 4;
  localparam int CICR_PORT_CHANGE_ENABLE = 3;
  localparam int CICR_TIMER0_OVERFLOW_FLAG = 2;
  localparam int CICR_EXT_PIN0_FLAG = 1;
  localparam int CICR_PORT_CHANGE_FLAG = 0;

  // Edge and priority control register fields.
  localparam int CICR_PORT_PULLUP_DISABLE = 7;
  localparam int CICR_EXT_PIN0_EDGE_SELECT = 6;
  localparam int CICR_EXT_PIN1_EDGE_SELECT = 5;
  localparam int CICR_EXT_PIN2_EDGE_SELECT = 4;
  localparam int CICR_TIMER0_OVERFLOW_PRIORITY = 2;
  localparam int CICR_PORT_CHANGE_PRIORITY = 0;

  // Mode register and status register fields.
  localparam int CICR_PRIORITY_MODE_ENABLE = 7;
  localparam int CICR_STAT_REQ = 0;
  localparam int CICR_STAT_HIGH = 1;
  localparam int CICR_STAT_SERV_LSB = 4;
  localparam int CICR_STAT_VEC_LSB = 16;

  // Reset values and writable masks.
  localparam logic [7:0] CICR_MAIN_RST = 8'h00;
  localparam logic [7:0] CICR_EDGE_RST = 8'hF5;
  localparam logic [7:0] CICR_EDGE_MASK = 8'hF5;
  localparam logic CICR_MODE_RST = 1'b0;

  // Interrupt vectors.
  localparam logic [15:0] CICR_VEC_HIGH = 16'h0008;
  localparam logic [15:0] CICR_VEC_LOW = 16'h0018;

  // Pin counts.
  localparam int CICR_EXT_PINS = 3;
  localparam int CICR_PORT_PINS = 4;

  // Bus encodings.
  localparam logic [1:0] CICR_HTRANS_NONSEQ = 2'b10;
  localparam logic CICR_HRESP_OKAY = 1'b0;

  typedef enum logic [3:0] {
    CICR_SV_NONE = 4'b0001,
    CICR_SV_LOW = 4'b0010,
    CICR_SV_HIGH = 4'b0100,
    CICR_SV_BOTH = 4'b1000
  } cicr_serv_e;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } cicr_ahb_in_s;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } cicr_ahb_out_s;

  typedef struct packed {
    logic req;
    logic high;
    logic [15:0] vector;
  } cicr_core_req_s;

  typedef struct packed {
    logic taken;
    logic ret;
  } cicr_core_ev_s;

  typedef struct packed {
    logic [7:0] main_ctl;
    logic [7:0] edge_ctl;
    logic prio_mode;
    cicr_serv_e serv;
    logic [CICR_PORT_PINS-1:0] port_latch;
    logic wr_pend;
    logic [CICR_OFS_W-1:0] wr_addr;
    logic [31:0] rdata;
  } cicr_state_s;

endpackage : cicr_pkg

// ### hw/cicr_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

module cicr_pin_sync #(
  parameter int WIDTH = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Raw pins
  input wire logic [WIDTH-1:0] pins,
  // Synchronised level and edges
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] prev;
  } cicr_sync_s;

  cicr_sync_s st;
  cicr_sync_s next_st;

  // Only the second stage reads the first, so metastability stays contained.
  always_comb begin
    next_st = st;
    next_st.s1 = pins;
    next_st.s2 = st.s1;
    next_st.prev = st.s2;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.s2;
  assign rise = st.s2 & ~st.prev;
  assign fall = ~st.s2 & st.prev;

endmodule : cicr_pin_sync

`default_nettype wire

// ### hw/cicr_core_regs.sv
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Both control registers readable and writable.
// - Flags set regardless of any enable.
// - Compat mode: bit 7 master enable.
// - Priority mode: bit 7 high global enable.
// - Compat mode: bit 6 gates peripheral sources.
// - Priority mode: bit 6 low global enable.
// - Timer overflow requests only when enabled.
// - External pin 0 requests only when enabled.
// - Port change requests only when enabled.
// - Timer flag set on overflow, software clears.
// - Pin 0 flag set on selected edge.
// - Port flag set on upper pin change.
// - Mismatch keeps setting port flag until read.
// - Port change priority bit picks level.
// - Mode bit switches to priority meanings.
// - High vector 0008h, low 0018h.
// - Taking interrupt clears admitting global enable.
// - Pin events flagged within few cycles.
module cicr_core_regs #(
  parameter int PORT_PINS = cicr_pkg::CICR_PORT_PINS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register bus
  input wire cicr_pkg::cicr_ahb_in_s ahb_in,
  output var cicr_pkg::cicr_ahb_out_s ahb_out,
  // Event sources
  input wire logic timer0_overflow,
  input wire logic [cicr_pkg::CICR_EXT_PINS-1:0] ext_pin,
  input wire logic [PORT_PINS-1:0] upper_port_pins,
  input wire logic port_b_read,
  input wire logic periph_high_req,
  input wire logic periph_low_req,
  // Port control and edge events for other flag registers
  output logic port_pullup_disable,
  output logic ext_pin1_event,
  output logic ext_pin2_event,
  // Core
  input wire cicr_pkg::cicr_core_ev_s core_ev,
  output var cicr_pkg::cicr_core_req_s core_req
);
  import cicr_pkg::*;

  localparam int NPINS = CICR_EXT_PINS + PORT_PINS;

  cicr_state_s st;
  cicr_state_s next_st;
  logic [NPINS-1:0] pin_level;
  logic [NPINS-1:0] pin_rise;
  logic [NPINS-1:0] pin_fall;
  logic [CICR_EXT_PINS-1:0] edge_sel;
  logic [CICR_EXT_PINS-1:0] ext_event;
  logic port_mismatch;
  logic src_t0;
  logic src_i0;
  logic src_rb;
  logic req_compat;
  logic req_high;
  logic req_low;
  logic addr_phase;

  ////////////////////////////////////////////////////////////////////////////

  // Selects one register from a byte offset; shared by write and read decode.
  function automatic logic [3:0] reg_sel(input logic [CICR_OFS_W-1:0] ofs);
    reg_sel = {ofs == CICR_OFS_STAT, ofs == CICR_OFS_MODE,
               ofs == CICR_OFS_EDGE, ofs == CICR_OFS_MAIN};
  endfunction : reg_sel

  function automatic logic [31:0] read_word(input cicr_state_s s,
                                            input logic [CICR_OFS_W-1:0] ofs,
                                            input logic [15:0] vec,
                                            input logic rq,
                                            input logic hi);
    logic [3:0] sel;
    sel = reg_sel(ofs);
    read_word = '0;
    if (sel[0]) begin
      read_word[7:0] = s.main_ctl;
    end
    if (sel[1]) begin
      read_word[7:0] = s.edge_ctl & CICR_EDGE_MASK;
    end
    if (sel[2]) begin
      read_word[CICR_PRIORITY_MODE_ENABLE] = s.prio_mode;
    end
    if (sel[3]) begin
      read_word[CICR_STAT_REQ] = rq;
      read_word[CICR_STAT_HIGH] = hi;
      read_word[CICR_STAT_SERV_LSB +: 4] = s.serv;
      read_word[CICR_STAT_VEC_LSB +: 16] = vec;
    end
  endfunction : read_word

  ////////////////////////////////////////////////////////////////////////////

  // Pins are synchronised before any edge or mismatch logic looks at them.
  cicr_pin_sync #(
    .WIDTH(NPINS)
  ) u_pin_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pins({upper_port_pins, ext_pin}),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign edge_sel = {st.edge_ctl[CICR_EXT_PIN2_EDGE_SELECT],
                     st.edge_ctl[CICR_EXT_PIN1_EDGE_SELECT],
                     st.edge_ctl[CICR_EXT_PIN0_EDGE_SELECT]};

  for (genvar k = 0; k < CICR_EXT_PINS; k++) begin : g_edge
    assign ext_event[k] = edge_sel[k] ? pin_rise[k] : pin_fall[k];
  end

  // The latch only follows the pins when the port is read, so a lasting
  // difference keeps re-setting the flag.
  assign port_mismatch = pin_level[NPINS-1:CICR_EXT_PINS] != st.port_latch;

  assign ext_pin1_event = ext_event[1];
  assign ext_pin2_event = ext_event[2];
  assign port_pullup_disable = st.edge_ctl[CICR_PORT_PULLUP_DISABLE];

  ////////////////////////////////////////////////////////////////////////////

  assign src_t0 = st.main_ctl[CICR_TIMER0_OVERFLOW_FLAG]
                & st.main_ctl[CICR_TIMER0_OVERFLOW_ENABLE];
  assign src_i0 = st.main_ctl[CICR_EXT_PIN0_FLAG] & st.main_ctl[CICR_EXT_PIN0_ENABLE];
  assign src_rb = st.main_ctl[CICR_PORT_CHANGE_FLAG]
                & st.main_ctl[CICR_PORT_CHANGE_ENABLE];

  // Compatibility mode ignores every priority bit.
  assign req_compat = st.main_ctl[CICR_GLOBAL_OR_HIGH_ENABLE]
    & (src_t0 | src_i0 | src_rb
       | (st.main_ctl[CICR_PERIPHERAL_OR_LOW_ENABLE]
          & (periph_high_req | periph_low_req)));

  // External pin 0 has no priority bit and is always high.
  assign req_high = st.main_ctl[CICR_GLOBAL_OR_HIGH_ENABLE]
    & ((src_t0 & st.edge_ctl[CICR_TIMER0_OVERFLOW_PRIORITY]) | src_i0
       | (src_rb & st.edge_ctl[CICR_PORT_CHANGE_PRIORITY]) | periph_high_req)
    & (st.serv inside {CICR_SV_NONE, CICR_SV_LOW});

  // A clear high enable blocks the low level too; lows wait out any service.
  assign req_low = st.main_ctl[CICR_GLOBAL_OR_HIGH_ENABLE]
    & st.main_ctl[CICR_PERIPHERAL_OR_LOW_ENABLE]
    & ((src_t0 & ~st.edge_ctl[CICR_TIMER0_OVERFLOW_PRIORITY])
       | (src_rb & ~st.edge_ctl[CICR_PORT_CHANGE_PRIORITY]) | periph_low_req)
    & (st.serv == CICR_SV_NONE);

  always_comb begin
    core_req.req = st.prio_mode ? (req_high | req_low) : req_compat;
    core_req.high = st.prio_mode ? req_high : req_compat;
    core_req.vector = (st.prio_mode && !req_high) ? CICR_VEC_LOW : CICR_VEC_HIGH;
  end

  ////////////////////////////////////////////////////////////////////////////

  assign addr_phase = ahb_in.hsel && ahb_in.hready && (ahb_in.htrans == CICR_HTRANS_NONSEQ);

  always_comb begin
    logic [3:0] wsel;
    wsel = reg_sel(st.wr_addr);
    next_st = st;

    // Write data phase; unmapped and status offsets ignore writes.
    if (st.wr_pend) begin
      if (wsel[0]) begin
        next_st.main_ctl = ahb_in.hwdata[7:0];
      end
      if (wsel[1]) begin
        next_st.edge_ctl = ahb_in.hwdata[7:0] & CICR_EDGE_MASK;
      end
      if (wsel[2]) begin
        next_st.prio_mode = ahb_in.hwdata[CICR_PRIORITY_MODE_ENABLE];
      end
    end

    // Events are applied after the write so a same-cycle clear loses.
    if (timer0_overflow) begin
      next_st.main_ctl[CICR_TIMER0_OVERFLOW_FLAG] = 1'b1;
    end
    if (ext_event[0]) begin
      next_st.main_ctl[CICR_EXT_PIN0_FLAG] = 1'b1;
    end
    if (port_mismatch) begin
      next_st.main_ctl[CICR_PORT_CHANGE_FLAG] = 1'b1;
    end
    if (port_b_read) begin
      next_st.port_latch = pin_level[NPINS-1:CICR_EXT_PINS];
    end

    // Taking an interrupt drops the enable that admitted it.
    if (core_ev.taken && core_req.req) begin
      if (!st.prio_mode || req_high) begin
        next_st.main_ctl[CICR_GLOBAL_OR_HIGH_ENABLE] = 1'b0;
        next_st.serv = (st.serv == CICR_SV_LOW) ? CICR_SV_BOTH : CICR_SV_HIGH;
      end else begin
        next_st.main_ctl[CICR_PERIPHERAL_OR_LOW_ENABLE] = 1'b0;
        next_st.serv = CICR_SV_LOW;
      end
    end else if (core_ev.ret) begin
      unique case (st.serv)
        CICR_SV_BOTH: begin
          next_st.main_ctl[CICR_GLOBAL_OR_HIGH_ENABLE] = 1'b1;
          next_st.serv = CICR_SV_LOW;
        end
        CICR_SV_LOW: begin
          next_st.main_ctl[CICR_PERIPHERAL_OR_LOW_ENABLE] = 1'b1;
          next_st.serv = CICR_SV_NONE;
        end
        CICR_SV_HIGH, CICR_SV_NONE: begin
          next_st.main_ctl[CICR_GLOBAL_OR_HIGH_ENABLE] = 1'b1;
          next_st.serv = CICR_SV_NONE;
        end
      endcase
    end

    // Address phase. Read data are taken from the next state so that a write
    // still in its data phase is already visible to a read behind it.
    next_st.wr_pend = addr_phase && ahb_in.hwrite;
    if (addr_phase) begin
      next_st.wr_addr = ahb_in.haddr[CICR_OFS_W-1:0];
    end
    if (addr_phase && !ahb_in.hwrite) begin
      next_st.rdata = read_word(next_st, ahb_in.haddr[CICR_OFS_W-1:0], core_req.vector,
                                core_req.req, core_req.high);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st.main_ctl <= CICR_MAIN_RST;
      st.edge_ctl <= CICR_EDGE_RST;
      st.prio_mode <= CICR_MODE_RST;
      st.serv <= CICR_SV_NONE;
      st.port_latch <= '0;
      st.wr_pend <= 1'b0;
      st.wr_addr <= '0;
      st.rdata <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Zero-wait slave: always ready, always OKAY.
  always_comb begin
    ahb_out.hreadyout = 1'b1;
    ahb_out.hresp = CICR_HRESP_OKAY;
    ahb_out.hrdata = st.rdata;
  end

endmodule : cicr_core_regs

`default_nettype wire

// ### dv/cicr_monitor.sv
`timescale 1ns/10ps
`default_nettype none

module cicr_monitor
  import cicr_pkg::*;
#(
  parameter int PORT_PINS = CICR_PORT_PINS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Watched ports
  input wire cicr_pkg::cicr_ahb_in_s ahb_in,
  input wire cicr_pkg::cicr_ahb_out_s ahb_out,
  input wire logic [cicr_pkg::CICR_EXT_PINS-1:0] ext_pin,
  input wire logic ext_pin1_event,
  input wire logic port_pullup_disable,
  input wire cicr_pkg::cicr_core_ev_s core_ev,
  input wire cicr_pkg::cicr_core_req_s core_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  wire logic rd = ahb_in.hsel && ahb_in.hready && !ahb_in.hwrite
    && ahb_in.htrans == CICR_HTRANS_NONSEQ;
  ////////////////////////////////////////
  a_bus_okay: assert property (
    ahb_out.hreadyout && ahb_out.hresp == CICR_HRESP_OKAY) else $error("bus not ready");
  a_void_zero: assert property (
    rd && ahb_in.haddr[7:0] == 8'h10 |=> ahb_out.hrdata == 32'h0) else $error("unmapped read");
  a_edge_unused: assert property (
    rd && ahb_in.haddr[7:0] == CICR_OFS_EDGE |=> ahb_out.hrdata[31:8] == 24'h0
    && !ahb_out.hrdata[3] && !ahb_out.hrdata[1]) else $error("unused bits not zero");
  a_pullup_reset: assert property (
    $rose(reset_n) |-> port_pullup_disable) else $error("pull-up reset value");
  a_reset_quiet: assert property (
    $rose(reset_n) |-> !core_req.req) else $error("request out of reset");
  a_vec_high: assert property (
    core_req.req && core_req.high |-> core_req.vector == CICR_VEC_HIGH) else $error("high vector");
  a_vec_low: assert property (
    core_req.req && core_req.vector == CICR_VEC_LOW |-> !core_req.high) else $error("low vector");
  a_take_blocks: assert property (
    core_ev.taken && core_req.req && core_req.high |=> !core_req.req) else $error("still enabled");
  a_pin_edge: assert property (
    ext_pin1_event |-> $past(ext_pin[1], 2) != $past(ext_pin[1], 3)) else $error("false edge");
  c_take: cover property (core_ev.taken && core_req.req);
  c_low: cover property (core_req.req && !core_req.high);
  c_pin: cover property (ext_pin1_event);
endmodule : cicr_monitor

bind cicr_core_regs cicr_monitor #(.PORT_PINS(PORT_PINS)) mon_u (.clk(clk), .reset_n(reset_n),
  .ahb_in(ahb_in), .ahb_out(ahb_out), .ext_pin(ext_pin), .ext_pin1_event(ext_pin1_event),
  .port_pullup_disable(port_pullup_disable), .core_ev(core_ev), .core_req(core_req));

`default_nettype wire

// ### dv/cicr_core_model.sv
`timescale 1ns/10ps
`default_nettype none

module cicr_core_model
  import cicr_pkg::*;
#(
  parameter int SERVE = 30
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bench control
  input wire logic go,
  input wire logic [3:0] delay,
  // Device side
  input wire cicr_pkg::cicr_core_req_s core_req,
  output var cicr_pkg::cicr_core_ev_s core_ev
);
  int cnt;
  logic busy;
  // A take is only issued while the request still stands; a withdrawn request restarts the wait.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      core_ev <= '0;
      busy <= 1'b0;
      cnt <= 0;
    end else begin
      core_ev <= '0;
      cnt <= cnt + 1;
      if (busy && cnt >= SERVE) begin
        core_ev.ret <= 1'b1;
        busy <= 1'b0;
        cnt <= 0;
      end else if (!busy && !(go && core_req.req)) begin
        cnt <= 0;
      end else if (!busy && cnt >= delay) begin
        core_ev.taken <= 1'b1;
        busy <= 1'b1;
        cnt <= 0;
      end
    end
  end
endmodule : cicr_core_model

`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import cicr_pkg::*;
  logic clk, reset_n, tmr, pbr, phi, plo, go, pud;
  logic [2:0] pins;
  logic [3:0] upp, dly;
  logic [31:0] rd, r;
  cicr_ahb_in_s ai;
  cicr_ahb_out_s ao;
  cicr_core_ev_s ev;
  cicr_core_req_s rq;
  int num_errors, n_tests, mdl[2];
  int unsigned seed = 65950;

  cicr_core_regs dut_u (.clk(clk), .reset_n(reset_n), .ahb_in(ai), .ahb_out(ao),
    .timer0_overflow(tmr), .ext_pin(pins), .upper_port_pins(upp), .port_b_read(pbr),
    .periph_high_req(phi), .periph_low_req(plo), .port_pullup_disable(pud),
    .ext_pin1_event(), .ext_pin2_event(), .core_ev(ev), .core_req(rq));
  cicr_core_model cpu_u (.clk(clk), .reset_n(reset_n), .go(go), .delay(dly),
    .core_req(rq), .core_ev(ev));
  ////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    ai.haddr <= {24'h0, a};
    ai.hwrite <= w;
    ai.htrans <= CICR_HTRANS_NONSEQ;
    do @(posedge clk); while (ao.hreadyout !== 1'b1);
    ai.htrans <= 2'b00;
    ai.hwdata <= {24'h0, d};
    do @(posedge clk); while (ao.hreadyout !== 1'b1);
    rd = ao.hrdata;
    if (w && a == CICR_OFS_MAIN) mdl[0] = d;
    if (w && a == CICR_OFS_EDGE) mdl[1] = d & CICR_EDGE_MASK;
  endtask : bus

  task automatic rdm(input logic [7:0] a);
    bus(a, 1'b0, 8'h00);
    check(rd, 32'(mdl[a >> 2]));
  endtask : rdm

  // The high bit is only compared where the mode gives it a meaning.
  task automatic req_ck(input logic [7:0] m, input logic [17:0] e, input logic hk);
    bus(CICR_OFS_MAIN, 1'b1, m);
    @(posedge clk);
    if (e[17]) check(32'({rq.req, hk ? rq.high : e[16], rq.vector}), 32'(e));
    else check(32'(rq.req), 32'h0);
  endtask : req_ck

  task automatic tally_and_finish();
    if (num_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    ai = '0;
    ai.hsel = 1'b1;
    ai.hready = 1'b1;
    ai.hsize = 3'b010;
    {reset_n, tmr, pbr, phi, plo, go, pins, upp, dly} = '0;
    mdl = '{32'h00, 32'hF5};
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rdm(CICR_OFS_MAIN);
    rdm(CICR_OFS_EDGE);
    for (int i = 0; i < 6; i++) begin
      r = xs();
      bus(CICR_OFS_MAIN, 1'b1, r[7:0]);
      bus(CICR_OFS_EDGE, 1'b1, r[15:8]);
      bus(8'h10, 1'b1, r[23:16]);
      rdm(CICR_OFS_MAIN);
      rdm(CICR_OFS_EDGE);
      // The pull-up output is a register launched at the edge write's last edge, three transfers earlier; look one edge on.
      @(posedge clk);
      check(32'(pud), 32'(r[15]));
    end
    bus(8'h10, 1'b0, 8'h00);
    check(rd, 32'h0);
    bus(CICR_OFS_EDGE, 1'b1, 8'hF5);
    bus(CICR_OFS_MAIN, 1'b1, 8'h00);
    tmr <= 1'b1;
    @(posedge clk);
    tmr <= 1'b0;
    mdl[0] = 32'h04;
    rdm(CICR_OFS_MAIN);
    check(32'(rq.req), 32'h0);
    bus(CICR_OFS_MAIN, 1'b1, 8'h00);
    rdm(CICR_OFS_MAIN);
    for (int s = 0; s < 2; s++) begin
      bus(CICR_OFS_EDGE, 1'b1, {1'b1, {3{s[0]}}, 4'h5});
      for (int lv = 1; lv >= 0; lv--) begin
        pins <= {3{lv[0]}};
        repeat (5) @(posedge clk);
        mdl[0] = (lv == s) ? 32'h02 : 32'h00;
        rdm(CICR_OFS_MAIN);
        bus(CICR_OFS_MAIN, 1'b1, 8'h00);
      end
    end
    upp <= 4'(xs()) | 4'h1;
    repeat (5) @(posedge clk);
    mdl[0] = 32'h01;
    rdm(CICR_OFS_MAIN);
    bus(CICR_OFS_MAIN, 1'b1, 8'h00);
    mdl[0] = 32'h01;
    rdm(CICR_OFS_MAIN);
    pbr <= 1'b1;
    @(posedge clk);
    pbr <= 1'b0;
    repeat (4) @(posedge clk);
    bus(CICR_OFS_MAIN, 1'b1, 8'h00);
    rdm(CICR_OFS_MAIN);
    req_ck(8'hA4, {2'b10, CICR_VEC_HIGH}, 1'b0);
    req_ck(8'h24, 18'h0, 1'b0);
    req_ck(8'h84, 18'h0, 1'b0);
    req_ck(8'hA4, {2'b10, CICR_VEC_HIGH}, 1'b0);
    dly <= 4'(xs());
    go <= 1'b1;
    for (int k = 0; k < 100 && ev.taken !== 1'b1; k++) @(posedge clk);
    go <= 1'b0;
    mdl[0] = 32'h24;
    rdm(CICR_OFS_MAIN);
    for (int k = 0; k < 100 && ev.ret !== 1'b1; k++) @(posedge clk);
    mdl[0] = 32'hA4;
    rdm(CICR_OFS_MAIN);
    bus(CICR_OFS_MODE, 1'b1, 8'h80);
    bus(CICR_OFS_EDGE, 1'b1, 8'hF1);
    req_ck(8'hE4, {2'b10, CICR_VEC_LOW}, 1'b1);
    req_ck(8'h64, 18'h0, 1'b1);
    req_ck(8'hA4, 18'h0, 1'b1);
    req_ck(8'h89, {2'b11, CICR_VEC_HIGH}, 1'b1);
    bus(CICR_OFS_EDGE, 1'b1, 8'hF5);
    req_ck(8'hA4, {2'b11, CICR_VEC_HIGH}, 1'b1);
    bus(CICR_OFS_MODE, 1'b1, 8'h00);
    phi <= 1'b1;
    plo <= 1'b1;
    req_ck(8'hC0, {2'b10, CICR_VEC_HIGH}, 1'b0);
    req_ck(8'h80, 18'h0, 1'b0);
    tally_and_finish();
  end
endmodule : testbench

`default_nettype wire
